// [imd_regs.svh]
// Purpose: Register indices, field positions, reset values and cycle counts of the mul/div unit
// Assumes: Included by bare name; definitions only
// Notes:   Register port addresses are word indices
`ifndef IMD_REGS_SVH
`define IMD_REGS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IMD_IDX_REM      3'h0
`define IMD_IDX_LOW      3'h1
`define IMD_IDX_HIGH     3'h2
`define IMD_IDX_SECOND   3'h3
`define IMD_IDX_CTRL     3'h4

// ----------------------------------------
// Control fields and encodings
// ----------------------------------------
`define IMD_CTRL_START   7
`define IMD_CTRL_SEL     0
`define IMD_SEL_DIV      1'b0
`define IMD_SEL_MUL      1'b1

// ----------------------------------------
// Reset values and cycle counts
// ----------------------------------------
`define IMD_RST16        16'h0000
`define IMD_MUL_CYCLES   6'h10
`define IMD_DIV_CYCLES   6'h20

`endif

// [imd_pkg.sv]
// Purpose: Types shared by the mul/div unit files
// Assumes: Used only through scoped names
// Notes:   Accumulator struct carries all working state of one step
package imd_pkg;

  // Register port request
  typedef struct packed {
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
    logic [2:0]  addr;   // Register index
    logic [1:0]  be;     // Byte enables, bit 1 = upper byte
    logic [15:0] wdata;  // Write data
  } imd_req_t;

  // Working registers: result high, result low, remainder
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] rem;
  } imd_acc_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    IMD_IDLE = 2'b01,
    IMD_BUSY = 2'b10
  } imd_state_t;

endpackage

// [imd_step.sv]
// Purpose: One bit of shift-and-add multiply or restoring divide
// Assumes: Purely combinational, called once per clock by the sequencer
// Notes:   Unsigned operands only
`timescale 1ns/1ps

module imd_step (
  // Mode and operands
  input  wire logic             i_mul,
  input  wire imd_pkg::imd_acc_t i_acc,
  input  wire logic [15:0]      i_divisor,
  // Next state
  output imd_pkg::imd_acc_t     o_acc
);

  // ----------------------------------------
  // Step arithmetic
  // ----------------------------------------
  logic [16:0] sum;      // Multiply partial sum with carry
  logic [16:0] shifted;  // Divide partial remainder after shift
  logic [16:0] diff;     // Trial subtraction

  // Both paths computed; mode picks one
  always_comb begin
    sum     = {1'b0, i_acc.hi} + (i_acc.lo[0] ? {1'b0, i_divisor} : 17'h00000);
    shifted = {i_acc.rem, i_acc.hi[15]};
    diff    = shifted - {1'b0, i_divisor};
    if (i_mul) begin
      // Add B when multiplier bit set, shift right into low half
      o_acc.hi  = sum[16:1];
      o_acc.lo  = {sum[0], i_acc.lo[15:1]};
      o_acc.rem = 16'h0000; // Remainder stays zero in multiply
    end else begin
      // Shift dividend left, quotient bit enters at bit 0
      o_acc.hi = {i_acc.hi[14:0], i_acc.lo[15]};
      // A zero divisor always subtracts: quotient all ones, no hang
      if (shifted >= {1'b0, i_divisor}) begin
        o_acc.lo  = {i_acc.lo[14:0], 1'b1};
        o_acc.rem = diff[15:0];
      end else begin
        o_acc.lo  = {i_acc.lo[14:0], 1'b0};
        o_acc.rem = shifted[15:0];
      end
    end
  end

endmodule

// [imd_unit.sv]
// Purpose: Memory-mapped iterative 16x16 multiplier and 32/16 divider
// Assumes: CPU register port synchronous to i_clock; one access per strobe
// Notes:   Operand writes are ignored while an operation runs
`timescale 1ns/1ps
`include "imd_regs.svh"

// Contract
// - Multiply 16x16 into 32-bit product
// - Divide 32 by 16: quotient, remainder
// - Select bit: 0 divide, 1 multiply
// - Result lands in operand/result register halves
// - Remainder zero after multiply
// - Start clears the remainder register
// - Remainder read-only, byte or halfword reads
// - Result halves writable by byte or halfword
// - Reset clears remainder and result halves
// - Multiply start clears result high half
// - Result register updates every clock while running
// - Multiply completes after 16 clocks
// - Divide completes after 32 clocks
// - Completion clears start, then raises interrupt
// - Second operand register, resets to zero
module imd_unit (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // Register port
  input  wire imd_pkg::imd_req_t i_req,
  output logic [15:0]            o_rdata,
  output logic                   o_rd_valid,
  // Completion event
  output logic                   o_arith_done_irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  imd_pkg::imd_acc_t   acc_r;          // Result halves and remainder
  imd_pkg::imd_acc_t   acc_nxt;        // One step ahead
  imd_pkg::imd_state_t state_r;        // Start bit lives here
  logic [15:0]         second_operand_r; // Multiplicand B or divisor
  logic                mul_sel_r;      // Mode select
  logic [5:0]          cnt_r;          // Steps done
  logic                done_r;         // Finish seen, start bit already clear
  logic                irq_r;          // Completion pulse
  logic [15:0]         rdata_r;        // Read data
  logic                rd_valid_r;     // Read answer strobe

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic busy;        // Start bit as software sees it
  logic ctrl_wr;     // Low byte write of control
  logic start_fire;  // Start bit written one
  logic abort;       // Start bit written zero mid-run
  logic last_step;   // This edge finishes the operation

  // Merge byte lanes of a write into a halfword
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign busy       = (state_r == imd_pkg::IMD_BUSY);
  assign ctrl_wr    = i_req.wr && (i_req.addr == `IMD_IDX_CTRL) && i_req.be[0];
  assign start_fire = ctrl_wr && i_req.wdata[`IMD_CTRL_START];
  assign abort      = ctrl_wr && !i_req.wdata[`IMD_CTRL_START] && busy;
  assign last_step  = busy && (cnt_r == (mul_sel_r ? `IMD_MUL_CYCLES - 6'h01 : `IMD_DIV_CYCLES - 6'h01));

  // Datapath step
  imd_step imd_step_inst (
    .i_mul     (mul_sel_r),
    .i_acc     (acc_r),
    .i_divisor (second_operand_r),
    .o_acc     (acc_nxt)
  );

  // ----------------------------------------
  // Control and sequencing
  // ----------------------------------------
  // Start, abort and self-clear of the start bit
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r   <= imd_pkg::IMD_IDLE;
      mul_sel_r <= `IMD_SEL_DIV;
      cnt_r     <= 6'h00;
    end else begin
      if (ctrl_wr) begin
        // A new start restarts the count; mode taken with it
        mul_sel_r <= i_req.wdata[`IMD_CTRL_SEL];
        state_r   <= start_fire ? imd_pkg::IMD_BUSY : imd_pkg::IMD_IDLE;
        cnt_r     <= 6'h00;
      end else if (busy) begin
        cnt_r <= cnt_r + 6'h01;
        // Self-clear after 16 or 32 steps
        if (last_step) begin
          state_r <= imd_pkg::IMD_IDLE;
        end
      end
    end
  end

  // Start bit clears first; the interrupt follows one clock later.
  // The extra stage keeps software from seeing the pulse while still busy.
  // Aborted runs raise nothing
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      done_r <= last_step && !ctrl_wr;
      irq_r  <= done_r;
    end
  end

  // ----------------------------------------
  // Operand and result registers
  // ----------------------------------------
  // Control writes win over running steps; running steps win over operand writes, which are dropped mid-run
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_r <= '{hi: `IMD_RST16, lo: `IMD_RST16, rem: `IMD_RST16};
    end else if (start_fire) begin
      acc_r.rem <= 16'h0000;
      if (i_req.wdata[`IMD_CTRL_SEL] == `IMD_SEL_MUL) begin
        acc_r.hi <= 16'h0000;
      end
    end else if (busy && !ctrl_wr) begin
      // Intermediate values land every clock
      acc_r <= acc_nxt;
    end else if (!busy && i_req.wr) begin
      // Byte or halfword writes of either half
      if (i_req.addr == `IMD_IDX_LOW) begin
        acc_r.lo <= merge16(acc_r.lo, i_req.wdata, i_req.be);
      end
      if (i_req.addr == `IMD_IDX_HIGH) begin
        acc_r.hi <= merge16(acc_r.hi, i_req.wdata, i_req.be);
      end
    end
  end

  // Second operand register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      second_operand_r <= `IMD_RST16;
    end else if (!busy && i_req.wr && (i_req.addr == `IMD_IDX_SECOND)) begin
      second_operand_r <= merge16(second_operand_r, i_req.wdata, i_req.be);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Full halfword returned; a byte read takes its lane. Remainder has no write path
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r    <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= i_req.rd;
      if (i_req.rd) begin
        unique case (i_req.addr)
          `IMD_IDX_REM:    rdata_r <= acc_r.rem;
          `IMD_IDX_LOW:    rdata_r <= acc_r.lo;
          `IMD_IDX_HIGH:   rdata_r <= acc_r.hi;
          `IMD_IDX_SECOND: rdata_r <= second_operand_r;
          `IMD_IDX_CTRL:   rdata_r <= {8'h00, busy, 6'h00, mul_sel_r};
          default:         rdata_r <= 16'h0000; // Unmapped reads zero
        endcase
      end
    end
  end

  assign o_rdata          = rdata_r;
  assign o_rd_valid       = rd_valid_r;
  assign o_arith_done_irq = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Operands captured at start for result checks
  logic [15:0] a_cap;
  logic [31:0] dvd_cap;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      a_cap   <= 16'h0000;
      dvd_cap <= 32'h00000000;
    end else if (start_fire) begin
      a_cap   <= acc_r.lo;
      dvd_cap <= {acc_r.hi, acc_r.lo};
    end
  end

  a_mul_length: assert property (@(posedge i_clock) disable iff (i_rst)
    (busy && mul_sel_r && !ctrl_wr) |-> (cnt_r <= 6'h0F) && ((cnt_r == 6'h0F) == last_step))
    else $error("multiply length wrong");
  a_div_length: assert property (@(posedge i_clock) disable iff (i_rst)
    (busy && !mul_sel_r && cnt_r == 6'h1F && !ctrl_wr) |=> !busy)
    else $error("divide did not end after 32 clocks");
  a_done_irq: assert property (@(posedge i_clock) disable iff (i_rst)
    (last_step && !ctrl_wr) |=> (!busy && !o_arith_done_irq) ##1 o_arith_done_irq)
    else $error("interrupt not after start bit clear");
  a_abort_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    abort |=> !busy ##1 !o_arith_done_irq ##1 !o_arith_done_irq)
    else $error("aborted run raised an interrupt");
  a_rem_start: assert property (@(posedge i_clock) disable iff (i_rst)
    start_fire |=> acc_r.rem == 16'h0000)
    else $error("remainder not cleared at start");
  a_high_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    (start_fire && i_req.wdata[`IMD_CTRL_SEL]) |=> acc_r.hi == 16'h0000 && busy)
    else $error("high half not cleared at multiply start");
  a_mul_product: assert property (@(posedge i_clock) disable iff (i_rst)
    (last_step && mul_sel_r && !ctrl_wr) |=> {acc_r.hi, acc_r.lo} == {16'h0000, a_cap} * {16'h0000, second_operand_r}
      && acc_r.rem == 16'h0000)
    else $error("product or zero remainder wrong");
  a_div_result: assert property (@(posedge i_clock) disable iff (i_rst)
    (last_step && !mul_sel_r && !ctrl_wr && second_operand_r != 16'h0000) |=>
      {acc_r.hi, acc_r.lo} == dvd_cap / {16'h0000, second_operand_r}
      && {16'h0000, acc_r.rem} == dvd_cap % {16'h0000, second_operand_r})
    else $error("quotient or remainder wrong");
  a_result_steps: assert property (@(posedge i_clock) disable iff (i_rst)
    (busy && !ctrl_wr) |=> ($past(cnt_r) + 6'h01 == cnt_r || !busy) && acc_r == $past(acc_nxt))
    else $error("step counter did not advance");
  a_mul_rem_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (busy && mul_sel_r) |-> acc_r.rem == 16'h0000)
    else $error("remainder nonzero in multiply");

endmodule

// [imd_cpu_model.sv]
// Purpose: CPU side of the register port
// Assumes: Requests change only at falling edges
// Notes:   Idle port shows inverted last request, never stale data
`timescale 1ns/1ps

module imd_cpu_model (
  // Clock
  input  wire logic         i_clock,
  // Register port
  output imd_pkg::imd_req_t o_req,
  input  wire logic [15:0]  i_rdata,
  input  wire logic         i_rd_valid
);
  // Idle from time zero
  initial begin
    o_req = '0;
  end

  // One write strobe, then idle
  task automatic wr(input logic [2:0] a, input logic [1:0] b, input logic [15:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
  endtask

  // One read strobe; ok stays low if no answer comes
  task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h0, wdata: 16'h0000};
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 2'h3, wdata: 16'hFFFF};
    for (n = 0; n < 3; n++) begin
      if (!ok && i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end
      if (!ok) @(negedge i_clock);
    end
  endtask
endmodule

// [tb_iterative_mul_div_unit.sv]
// Purpose: Self-checking bench of the mul/div unit
// Assumes: Inputs change on falling edges
// Notes:   Operands touched only while idle
`timescale 1ns/1ps
`include "imd_regs.svh"

module tb_iterative_mul_div_unit;
  // Clock, reset, port wires
  logic              i_clock;
  logic              i_rst;
  imd_pkg::imd_req_t req;
  logic [15:0]       rdata;
  logic              rd_valid;
  logic              irq;
  // Bookkeeping
  int                n_fail;
  int                check_count;
  logic              ok;
  logic [15:0]       r;
  logic [15:0]       h;

  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  imd_unit imd_unit_inst (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_arith_done_irq(irq));
  imd_cpu_model imd_cpu_model_inst (.i_clock(i_clock), .o_req(req),
    .i_rdata(rdata), .i_rd_valid(rd_valid));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [1:0] b, input logic [15:0] d);
    imd_cpu_model_inst.wr(a, b, d);
  endtask

  // A missing answer is fatal to the run
  task automatic rd(input logic [2:0] a);
    imd_cpu_model_inst.rd(a, r, ok);
    if (!ok) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Start, count clocks to the pulse, then expect start bit clear
  task automatic run(input logic [15:0] c, input int exp_n);
    int n;
    wr(`IMD_IDX_CTRL, 2'h1, c);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk(32'(n), 32'(exp_n));
    if (n >= 40) print_verdict();
    rd(`IMD_IDX_CTRL); // Reads wait for completion
    chk({16'h0000, r}, {24'h000000, 7'h00, c[0]});
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    int i;
    for (i = 0; i < 4; i++) begin
      rd(3'(i));
      chk({16'h0000, r}, 32'h00000000);
    end
    rd(3'h7);
    chk({16'h0000, r}, 32'h00000000); // Unmapped reads as zero
  endtask

  task automatic t_div();
    logic [31:0] x [3] = '{32'hDCBA2586, 32'hFFFFFFFF, 32'h00000005};
    logic [15:0] y [3] = '{16'h0018, 16'h0001, 16'h0007};
    int i;
    for (i = 0; i < 3; i++) begin
      wr(`IMD_IDX_HIGH, 2'h3, x[i][31:16]);
      wr(`IMD_IDX_LOW, 2'h3, x[i][15:0]);
      wr(`IMD_IDX_SECOND, 2'h3, y[i]);
      run(16'h0080, 33);
      rd(`IMD_IDX_HIGH);
      h = r;
      rd(`IMD_IDX_LOW);
      chk({h, r}, x[i] / {16'h0000, y[i]});
      rd(`IMD_IDX_REM);
      chk({16'h0000, r}, x[i] % {16'h0000, y[i]});
    end
  endtask

  task automatic t_mul();
    logic [15:0] a [2] = '{16'h00DA, 16'hFFFF};
    logic [15:0] b [2] = '{16'h0093, 16'hFFFF};
    int i;
    for (i = 0; i < 2; i++) begin
      wr(`IMD_IDX_LOW, 2'h3, a[i]);
      wr(`IMD_IDX_HIGH, 2'h3, 16'hA5A5);
      wr(`IMD_IDX_SECOND, 2'h3, b[i]);
      run(16'h0081, 17);
      rd(`IMD_IDX_HIGH);
      h = r;
      rd(`IMD_IDX_LOW);
      chk({h, r}, {16'h0000, a[i]} * {16'h0000, b[i]});
      rd(`IMD_IDX_REM);
      chk({16'h0000, r}, 32'h00000000);
    end
  endtask

  // Divisor zero still finishes on time
  task automatic t_zero();
    wr(`IMD_IDX_SECOND, 2'h3, 16'h0000);
    run(16'h0080, 33);
  endtask

  // Byte lanes and the read-only remainder
  task automatic t_bytes();
    wr(`IMD_IDX_LOW, 2'h3, 16'h1111);
    wr(`IMD_IDX_LOW, 2'h1, 16'h22CC);
    rd(`IMD_IDX_LOW);
    chk({16'h0000, r}, 32'h000011CC);
    wr(`IMD_IDX_LOW, 2'h2, 16'h3344);
    rd(`IMD_IDX_LOW);
    chk({16'h0000, r}, 32'h000033CC);
    wr(`IMD_IDX_REM, 2'h3, 16'hFFFF);
    rd(`IMD_IDX_REM);
    chk({16'h0000, r}, 32'h00000000);
  endtask

  // Start bit written zero mid-run stops the run with no interrupt
  task automatic t_abort();
    int   n;
    logic seen;
    wr(`IMD_IDX_CTRL, 2'h1, 16'h0080);
    wr(`IMD_IDX_CTRL, 2'h1, 16'h0000);
    seen = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge i_clock);
      if (irq !== 1'b0) seen = 1'b1;
    end
    chk({31'h00000000, seen}, 32'h00000000);
    rd(`IMD_IDX_CTRL);
    chk({16'h0000, r}, 32'h00000000);
  endtask

  // Main sequence
  initial begin
    n_fail      = 0;
    check_count = 0;
    i_rst       = 1'b1;
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset();
    t_div();
    t_zero();
    t_mul();
    t_bytes();
    t_abort();
    print_verdict();
  end
endmodule
